// ### hpsc_device.sv
// device end: host port handshake, local clocks, irq sync, boot mode
// assumes host end on the same clk; irq pins asynchronous
`include "hpsc_map.svh"
module hpsc_device (
    input  wire logic                 clk,          // input clock
    input  wire logic                 srst,         // sync reset, high
    hpsc_if.device                    port,         // host pins
    input  wire logic                 localIrqAN,   // irq level a, async low
    input  wire logic                 localIrqBN,   // irq level b, async low
    input  wire logic                 irqAck,       // core recognized irq, pulse
    input  wire logic                 haltClear,    // host wrote 0 to halt bit
    input  wire hpsc_pkg::hpsc_data_t localRdData,  // local read data
    output logic                      localClockA,  // local clock a
    output logic                      localClockB,  // local clock b, 90 deg late
    output logic                      irqReqA,      // synced irq a
    output logic                      irqReqB,      // synced irq b
    output logic                      halted,       // halted for host
    output logic                      bootStart,    // fetch reset vector, pulse
    output hpsc_pkg::hpsc_data_t      bootVector,   // reset vector address
    output logic                      accWrite,     // local write strobe, pulse
    output hpsc_pkg::hpsc_addr_t      accAddr,      // latched address
    output hpsc_pkg::hpsc_bsel_t      accBsel,      // latched byte selects
    output hpsc_pkg::hpsc_data_t      accData       // captured data, written or read
);
    import hpsc_pkg::*;
    typedef enum logic [2:0] {HPSC_IDLE, HPSC_RD, HPSC_WR_WAIT, HPSC_WR, HPSC_DONE} hpsc_dst_t;

    // ****************************************
    // local clock generation
    // ****************************************
    logic [1:0] phase, next_phase;   // quarter-period counter
    logic       phaseTick;           // one edge per quarter
    logic       lcA, next_lcA;       // clock a
    logic       lcB, next_lcB;       // clock b

    // no video clock here: video timing lives in its own block
    // divider and quarter phases
    always_comb begin
        next_phase = phase + 2'h1;
        phaseTick  = (phase == `HPSC_LCLK_DIV);
        next_lcA   = lcA;
        next_lcB   = lcB;
        if (phaseTick) begin
            next_lcA = lcB ? 1'b0 : 1'b1;
            next_lcB = lcA;                 // b trails a by a quarter
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 2'h0;
            lcA   <= 1'b0;
            lcB   <= 1'b0;
        end else begin
            phase <= next_phase;
            lcA   <= next_lcA;
            lcB   <= next_lcB;
        end
    end
    assign localClockA = lcA;
    assign localClockB = lcB;

    // ****************************************
    // interrupt synchronisers
    // ****************************************
    logic [1:0] irqMeta, next_irqMeta;   // first stage
    logic [1:0] irqSync, next_irqSync;   // second stage
    logic [1:0] irqReq, next_irqReq;     // held request

    // two flops then a held request per level
    always_comb begin
        next_irqMeta = {~localIrqBN, ~localIrqAN};
        next_irqSync = irqMeta;
        next_irqReq  = irqReq;
        if (phaseTick) begin
            next_irqReq = irqSync;
        end
        if (irqAck) begin
            next_irqReq = irqSync;                   // requester keeps level until ack
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irqMeta <= 2'h0;
            irqSync <= 2'h0;
            irqReq  <= 2'h0;
        end else begin
            irqMeta <= next_irqMeta;
            irqSync <= next_irqSync;
            irqReq  <= next_irqReq;
        end
    end
    assign irqReqA = irqReq[0];
    assign irqReqB = irqReq[1];

    // ****************************************
    // boot mode and halt
    // ****************************************
    logic inReset;                    // reset seen last cycle
    logic halt_bit, next_hlt;              // halt bit
    logic boot, next_boot;            // boot pulse

    // sample select at first edge after reset release
    always_comb begin
        next_hlt  = halt_bit;
        next_boot = 1'b0;
        if (inReset) begin
            next_hlt  = port.hostSelectN;   // high: halt
            next_boot = ~port.hostSelectN;  // low: run reset vector
        end else if (haltClear) begin
            next_hlt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            inReset <= 1'b1;
            halt_bit     <= 1'b1;
            boot    <= 1'b0;
        end else begin
            inReset <= 1'b0;
            halt_bit     <= next_hlt;
            boot    <= next_boot;
        end
    end
    assign halted     = halt_bit;
    assign bootStart  = boot;
    assign bootVector = `HPSC_RESET_VEC;

    // ****************************************
    // host access handshake
    // ****************************************
    hpsc_dst_t  state, next_state;    // access sequencer
    logic [3:0] cnt, next_cnt;        // local cycle timer
    logic       rdy, next_rdy;        // ready pin
    logic       dst, next_dst;        // read latch strobe
    logic       oeN, next_oeN;        // latch output enable
    logic       wr, next_wr;          // local write pulse
    hpsc_addr_t addr, next_addr;      // latched address
    hpsc_bsel_t bsel, next_bsel;      // latched byte selects
    hpsc_data_t wdat, next_wdat;      // captured access data
    logic       wrSeen, next_wrSeen;  // write strobe seen low

    // handshake sequencing
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_rdy    = rdy;
        next_dst    = dst;
        next_oeN    = oeN;
        next_wr     = 1'b0;
        next_addr   = addr;
        next_bsel   = bsel;
        next_wdat   = wdat;
        next_wrSeen = wrSeen;
        case (state)
            HPSC_IDLE: begin
                next_rdy = 1'b0;
                if (!port.hostSelectN) begin
                    next_addr = port.hostAddress;
                    next_bsel = port.hostByteSelects;
                    if (!port.hostReadStrobeN) begin
                        next_cnt   = `HPSC_ACC_CYC;
                        next_state = HPSC_RD;
                    end else if (!port.hostWriteStrobeN) begin
                        next_wrSeen = 1'b1;
                        next_state  = HPSC_WR_WAIT;
                    end
                end
            end
            HPSC_RD: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_wdat  = localRdData;               // read data held for the latch
                    next_dst   = 1'b1;
                    next_rdy   = 1'b1;
                    next_state = HPSC_DONE;
                end
            end
            HPSC_WR_WAIT: begin
                if (port.hostWriteStrobeN) begin            // rising edge of write
                    next_oeN   = 1'b0;
                    next_cnt   = `HPSC_ACC_CYC;
                    next_state = HPSC_WR;
                end
            end
            HPSC_WR: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h2) begin
                    next_wdat = port.latchData;
                    next_wr   = 1'b1;
                end
                if (cnt == 4'h1) begin
                    next_oeN   = 1'b1;
                    next_rdy   = 1'b1;
                    next_state = HPSC_DONE;
                end
            end
            default: begin
                // drop ready once strobes are released
                if (port.hostReadStrobeN && (port.hostWriteStrobeN || wrSeen)) begin
                    next_rdy    = 1'b0;
                    next_dst    = 1'b0;
                    next_wrSeen = 1'b0;
                    next_state  = HPSC_IDLE;
                end
            end
        endcase
    end

    // handshake registers, inactive in reset
    always_ff @(posedge clk) begin
        if (srst) begin
            state  <= HPSC_IDLE;
            cnt    <= 4'h0;
            rdy    <= 1'b0;
            dst    <= 1'b0;
            oeN    <= 1'b1;
            wr     <= 1'b0;
            addr   <= '0;
            bsel   <= '0;
            wdat   <= '0;
            wrSeen <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            rdy    <= next_rdy;
            dst    <= next_dst;
            oeN    <= next_oeN;
            wr     <= next_wr;
            addr   <= next_addr;
            bsel   <= next_bsel;
            wdat   <= next_wdat;
            wrSeen <= next_wrSeen;
        end
    end
    assign port.hostReady           = rdy;
    assign port.hostReadLatchStrobe = dst;
    assign port.hostLatchOutputEnN  = oeN;
    assign accWrite                 = wr;
    assign accAddr                  = addr;
    assign accBsel                  = bsel;
    assign accData                  = wdat;
endmodule

// ### hpsc_map.svh
// constants for the host port and system control block
// assumes inclusion by hpsc_pkg and both end modules
`ifndef HPSC_MAP_SVH
`define HPSC_MAP_SVH
`define HPSC_ADDR_W     27
`define HPSC_BSEL_W     4
`define HPSC_DATA_W     32
`define HPSC_LCLK_DIV   2'h3
`define HPSC_ACC_CYC    4'h4
`define HPSC_RESET_VEC  32'hFFFF_FFE0
`endif

// ### hpsc_pkg.sv
// types shared by both ends of the host port
// assumes hpsc_map.svh in the include path
`include "hpsc_map.svh"
package hpsc_pkg;
    typedef logic [`HPSC_ADDR_W-1:0] hpsc_addr_t;   // host long-word address
    typedef logic [`HPSC_BSEL_W-1:0] hpsc_bsel_t;   // byte selects
    typedef logic [`HPSC_DATA_W-1:0] hpsc_data_t;   // data word
endpackage

// ### hpsc_if.sv
// pins between host processor and device host port
// assumes one clock shared by both ends
interface hpsc_if;
    import hpsc_pkg::*;
    logic       hostSelectN;         // host select, low active
    logic       hostReadStrobeN;     // read request, low active
    logic       hostWriteStrobeN;    // write request, low active
    hpsc_addr_t hostAddress;         // long-word address
    hpsc_bsel_t hostByteSelects;     // byte selects
    logic       hostReady;           // device ready
    logic       hostReadLatchStrobe; // rising edge latches read data
    logic       hostLatchOutputEnN;  // latch output enable, low active
    hpsc_data_t latchData;           // external latch contents
    modport device (input hostSelectN, hostReadStrobeN, hostWriteStrobeN, hostAddress,
                    hostByteSelects, latchData,
                    output hostReady, hostReadLatchStrobe, hostLatchOutputEnN);
    modport host (output hostSelectN, hostReadStrobeN, hostWriteStrobeN, hostAddress,
                  hostByteSelects, latchData,
                  input hostReady, hostReadLatchStrobe, hostLatchOutputEnN);
endinterface

// ### hpsc_host.sv
// host processor end: issues one read or write per request
// assumes device end on the same clock
`include "hpsc_map.svh"
module hpsc_host (
    input  wire logic             clk,        // system clock
    input  wire logic             srst,       // sync reset, high
    hpsc_if.host                  port,       // host pins
    input  wire logic             reqValid,   // start access, pulse
    input  wire logic             reqWrite,   // 1 write, 0 read
    input  wire hpsc_pkg::hpsc_addr_t reqAddr,  // address
    input  wire hpsc_pkg::hpsc_bsel_t reqBsel,  // byte selects
    input  wire hpsc_pkg::hpsc_data_t reqData,  // write data
    output logic                  reqBusy,    // access in flight
    output logic                  rspDone     // access finished, pulse
);
    import hpsc_pkg::*;
    typedef enum logic [2:0] {HPSC_IDLE, HPSC_SEL, HPSC_WAIT, HPSC_RELEASE, HPSC_END} hpsc_hst_t;
    hpsc_hst_t  state, next_state;       // access sequencer
    logic       selN, next_selN;         // select pin
    logic       rdN, next_rdN;           // read strobe
    logic       wrN, next_wrN;           // write strobe
    hpsc_addr_t addr, next_addr;         // address pins
    hpsc_bsel_t bsel, next_bsel;         // byte selects
    hpsc_data_t data, next_data;         // latch data
    logic       isWr, next_isWr;         // kind of access
    logic       done, next_done;         // completion pulse

    assign port.hostSelectN      = selN;
    assign port.hostReadStrobeN  = rdN;
    assign port.hostWriteStrobeN = wrN;
    assign port.hostAddress      = addr;
    assign port.hostByteSelects  = bsel;
    assign port.latchData        = data;
    assign reqBusy               = (state != HPSC_IDLE);
    assign rspDone               = done;

    // next-state logic
    always_comb begin
        next_state = state;
        next_selN  = selN;
        next_rdN   = rdN;
        next_wrN   = wrN;
        next_addr  = addr;
        next_bsel  = bsel;
        next_data  = data;
        next_isWr  = isWr;
        next_done  = 1'b0;
        case (state)
            HPSC_IDLE: begin
                if (reqValid) begin
                    next_selN  = 1'b0;
                    next_addr  = reqAddr;
                    next_bsel  = reqBsel;
                    next_data  = reqData;       // latched before strobe rise
                    next_isWr  = reqWrite;
                    next_state = HPSC_SEL;
                end
            end
            HPSC_SEL: begin
                // only one strobe at a time
                if (isWr) begin
                    next_wrN = 1'b0;
                end else begin
                    next_rdN = 1'b0;
                end
                next_state = HPSC_WAIT;
            end
            HPSC_WAIT: begin
                if (isWr && !wrN) begin
                    next_wrN = 1'b1;            // strobe rise: data sits in the latch
                end else if (port.hostReady) begin
                    next_rdN   = 1'b1;
                    next_state = HPSC_RELEASE;
                end
            end
            HPSC_RELEASE: begin
                if (!port.hostReady) begin
                    next_selN  = 1'b1;
                    next_done  = 1'b1;
                    next_state = HPSC_END;
                end
            end
            default: begin
                next_state = HPSC_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= HPSC_IDLE;
            selN  <= 1'b1;
            rdN   <= 1'b1;
            wrN   <= 1'b1;
            addr  <= '0;
            bsel  <= '0;
            data  <= '0;
            isWr  <= 1'b0;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            selN  <= next_selN;
            rdN   <= next_rdN;
            wrN   <= next_wrN;
            addr  <= next_addr;
            bsel  <= next_bsel;
            data  <= next_data;
            isWr  <= next_isWr;
            done  <= next_done;
        end
    end
endmodule

// ### hpsc_monitor.sv
// checker for the host link between the host end and the device end
// assumes the testbench wires the link signals in by name, one clock domain
module hpsc_monitor (
    input wire logic clk,                 // system clock
    input wire logic srst,                // sync reset, high
    input wire logic hostSelectN,         // host select, low active
    input wire logic hostReadStrobeN,     // read request, low active
    input wire logic hostWriteStrobeN,    // write request, low active
    input wire logic hostReady,           // device ready
    input wire logic hostReadLatchStrobe, // read data latch strobe
    input wire logic hostLatchOutputEnN   // latch output enable, low active
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // clocking and reset for every property
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // outputs quiet on the first edge after reset
    property p_resetQuiet;
        $past(srst) |-> !hostReady && !hostReadLatchStrobe && hostLatchOutputEnN;
    endproperty
    a_resetQuiet: assert property (p_resetQuiet) else $error("outputs active after reset");
    // read taken while selected is answered within the access time
    property p_readAnswer;
        !hostSelectN && $fell(hostReadStrobeN) |-> ##[3:5] hostReady;
    endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read not answered in time");
    // no ready without a select
    property p_readyIdle;
        hostSelectN && !hostReady |=> !hostReady;
    endproperty
    a_readyIdle: assert property (p_readyIdle) else $error("ready raised while idle");
    // read ready comes with the latch strobe edge
    property p_latchWithReady;
        $rose(hostReady) && !hostReadStrobeN |-> hostReadLatchStrobe;
    endproperty
    a_latchWithReady: assert property (p_latchWithReady) else $error("no latch strobe with read ready");
    // ready stands while the read strobe is held
    property p_readyStands;
        hostReady && !hostReadStrobeN |=> hostReady;
    endproperty
    a_readyStands: assert property (p_readyStands) else $error("ready dropped during read");
    // ready falls one edge after strobes are released
    property p_readyDrop;
        hostReady && hostReadStrobeN && hostWriteStrobeN |=> !hostReady;
    endproperty
    a_readyDrop: assert property (p_readyDrop) else $error("ready held after release");
    // latch strobe falls one edge after read release
    property p_latchDrop;
        hostReadLatchStrobe && hostReadStrobeN |=> !hostReadLatchStrobe;
    endproperty
    a_latchDrop: assert property (p_latchDrop) else $error("latch strobe held after release");
    // latch does not drive during a read
    property p_readNoOe;
        !hostReadStrobeN && hostWriteStrobeN |-> hostLatchOutputEnN;
    endproperty
    a_readNoOe: assert property (p_readNoOe) else $error("latch enabled during read");
    // host never drives both strobes
    property p_oneStrobe;
        !(!hostReadStrobeN && !hostWriteStrobeN);
    endproperty
    a_oneStrobe: assert property (p_oneStrobe) else $error("both strobes low");
    // select released only after ready is low
    property p_selectAfterReady;
        $rose(hostSelectN) |-> !hostReady;
    endproperty
    a_selectAfterReady: assert property (p_selectAfterReady) else $error("select released with ready high");

    // ****************************************
    // coverage of the main cases
    // ****************************************
    c_readTaken: cover property (!hostSelectN && $fell(hostReadStrobeN));
    c_readyRose: cover property ($rose(hostReady));
    c_readyFell: cover property ($fell(hostReady));
endmodule

// ### test_host_port_and_system_control.sv
// testbench: host end and device end on one link, a direct driver on a second
// assumes design files and hpsc_map.svh are compiled before this file
`include "hpsc_map.svh"
module test_host_port_and_system_control;
    timeunit 1ns;
    timeprecision 100ps;
    import hpsc_pkg::*;
    typedef struct packed {logic wr; hpsc_addr_t addr; hpsc_bsel_t bsel; hpsc_data_t data;} hpsc_row_t;
    // ****************************************
    // stimulus table and signals
    // ****************************************
    hpsc_row_t  rows [4] = '{'{1'b0, 27'h000_0010, 4'hF, 32'h0000_0000}, '{1'b1, 27'h7FF_FFFF, 4'h1, 32'hA5A5_5A5A},
                             '{1'b0, 27'h555_5555, 4'h3, 32'h0000_0000}, '{1'b1, 27'h000_0000, 4'h8, 32'h0123_4567}};
    logic       clk = 1'b0;       // system clock
    logic       srst = 1'b1;      // sync reset
    logic       reqValid, reqWrite, rspDone, busy, ack, haltClr, lclkA, lclkB, aHalted, bHalted, bBoot, bWrite, seenOe, seenWr;
    logic [1:0] irqN, aIrq;       // irq pins, synced requests
    hpsc_addr_t reqAddr, aAddr, bAddr;
    hpsc_bsel_t reqBsel, aBsel, bBsel;
    hpsc_data_t reqData, rdData, aVec, aData, bData;
    int         failures = 0, compares = 0, bootCount = 0, n;
    time        tA, tB, tC;       // local clock edge times
    hpsc_if busA();               // host end to device end
    hpsc_if busB();               // bench driver to second device
    // ****************************************
    // instances
    // ****************************************
    hpsc_host u_hpsc_host (.clk(clk), .srst(srst), .port(busA), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqBsel(reqBsel), .reqData(reqData), .reqBusy(busy), .rspDone(rspDone));
    hpsc_device u_hpsc_device (.clk(clk), .srst(srst), .port(busA), .localIrqAN(irqN[0]), .localIrqBN(irqN[1]),
        .irqAck(ack), .haltClear(haltClr), .localRdData(rdData), .localClockA(lclkA), .localClockB(lclkB),
        .irqReqA(aIrq[0]), .irqReqB(aIrq[1]), .halted(aHalted), .bootStart(), .bootVector(aVec), .accWrite(),
        .accAddr(aAddr), .accBsel(aBsel), .accData(aData));
    hpsc_device u_hpsc_device_b (.clk(clk), .srst(srst), .port(busB), .localIrqAN(irqN[0]), .localIrqBN(irqN[1]),
        .irqAck(ack), .haltClear(haltClr), .localRdData(rdData), .localClockA(), .localClockB(), .irqReqA(),
        .irqReqB(), .halted(bHalted), .bootStart(bBoot), .bootVector(), .accWrite(bWrite), .accAddr(bAddr),
        .accBsel(bBsel), .accData(bData));
    hpsc_monitor u_hpsc_monitor (.clk(clk), .srst(srst), .hostSelectN(busA.hostSelectN),
        .hostReadStrobeN(busA.hostReadStrobeN), .hostWriteStrobeN(busA.hostWriteStrobeN), .hostReady(busA.hostReady),
        .hostReadLatchStrobe(busA.hostReadLatchStrobe), .hostLatchOutputEnN(busA.hostLatchOutputEnN));
    // clock and boot pulse counter
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (bBoot === 1'b1) bootCount++;
    end
    // ****************************************
    // tasks
    // ****************************************
    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // read or write through the host end, once the host is idle
    task automatic hostRow(input hpsc_row_t r);
        @(negedge clk);
        while (busy !== 1'b0) @(negedge clk);
        reqValid = 1'b1; reqWrite = r.wr; reqAddr = r.addr; reqBsel = r.bsel; reqData = r.data;
        @(negedge clk); reqValid = 1'b0;
        for (n = 0; n < 40 && rspDone !== 1'b1; n++) begin @(posedge clk); #1; end
        check("rspDone", 32'(rspDone), 32'h0000_0001);
        check("aAddr", 32'(aAddr), 32'(r.addr));
        check("aBsel", 32'(aBsel), 32'(r.bsel));
        check("aData", aData, r.wr ? r.data : rdData);
    endtask
    // write on the second link by direct drive
    task automatic writeRow(input hpsc_row_t r);
        @(negedge clk); busB.hostSelectN = 1'b0; busB.hostAddress = r.addr; busB.hostByteSelects = r.bsel;
        busB.latchData = r.data;
        @(negedge clk); busB.hostWriteStrobeN = 1'b0;
        repeat (2) @(negedge clk);
        busB.hostWriteStrobeN = 1'b1;
        seenOe = 1'b0; seenWr = 1'b0;
        for (n = 0; n < 20 && busB.hostReady !== 1'b1; n++) begin
            @(posedge clk); #1;
            if (busB.hostLatchOutputEnN === 1'b0) seenOe = 1'b1;
            if (bWrite === 1'b1) begin
                seenWr = 1'b1;
                check("bAddr", 32'(bAddr), 32'(r.addr));
                check("bBsel", 32'(bBsel), 32'(r.bsel));
                check("bData", bData, r.data);
            end
        end
        check("oeSeen", 32'(seenOe), 32'h0000_0001);
        check("wrSeen", 32'(seenWr), 32'h0000_0001);
        check("wReady", 32'(busB.hostReady), 32'h0000_0001);
        check("oeOff", 32'(busB.hostLatchOutputEnN), 32'h0000_0001);
        @(posedge clk); #1;
        check("wDrop", 32'(busB.hostReady), 32'h0000_0000);
        @(negedge clk); busB.hostSelectN = 1'b1; busB.latchData = ~r.data;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reqValid = 1'b0; reqWrite = 1'b0; reqAddr = '0; reqBsel = '0; reqData = '0; rdData = 32'h1234_ABCD;
        irqN = 2'h3; ack = 1'b0; haltClr = 1'b0;
        busB.hostSelectN = 1'b0; busB.hostReadStrobeN = 1'b1; busB.hostWriteStrobeN = 1'b1;
        busB.hostAddress = '0; busB.hostByteSelects = '0; busB.latchData = '0;
        repeat (9) @(negedge clk);
        check("rstReady", 32'(busA.hostReady), 32'h0000_0000);
        check("rstHalt", 32'(aHalted), 32'h0000_0001);
        @(negedge clk); srst = 1'b0;
        repeat (3) @(negedge clk);
        check("bootCount", 32'(bootCount), 32'h0000_0001);
        check("bHalted", 32'(bHalted), 32'h0000_0000);
        check("aHalted", 32'(aHalted), 32'h0000_0001);
        check("bootVector", aVec, `HPSC_RESET_VEC);
        busB.hostSelectN = 1'b1;
        haltClr = 1'b1;
        @(negedge clk); haltClr = 1'b0;
        repeat (2) @(negedge clk);
        check("haltCleared", 32'(aHalted), 32'h0000_0000);
        foreach (rows[i]) begin
            hostRow(rows[i]);
            if (rows[i].wr) writeRow(rows[i]);
        end
        // local clocks: 16-cycle period, quarter offset
        @(posedge lclkA); tA = $time;
        @(posedge lclkB); tB = $time;
        @(posedge lclkA); tC = $time;
        check("quarter", 32'(tB - tA), 32'h0000_0014);
        check("period", 32'(tC - tA), 32'h0000_0050);
        // each irq pin raises only its own request
        for (int i = 0; i < 2; i++) begin
            @(negedge clk); irqN[i] = 1'b0;
            for (n = 0; n < 40 && aIrq[i] !== 1'b1; n++) begin @(posedge clk); #1; end
            check("irqReq", 32'(aIrq), 32'(2'h1 << i));
            @(negedge clk); irqN[i] = 1'b1; ack = 1'b1; // held low until recognized
            @(negedge clk); ack = 1'b0;
            for (n = 0; n < 40 && aIrq[i] !== 1'b0; n++) begin @(posedge clk); #1; end
            check("irqClr", 32'(aIrq), 32'h0000_0000);
        end
        // read strobe without select is not taken
        @(negedge clk); busB.hostReadStrobeN = 1'b0;
        repeat (8) @(negedge clk);
        check("noSelect", 32'(busB.hostReady), 32'h0000_0000);
        // both strobes low is served as a read
        busB.hostSelectN = 1'b0; busB.hostWriteStrobeN = 1'b0; seenWr = 1'b0;
        for (n = 0; n < 20 && busB.hostReady !== 1'b1; n++) begin
            @(posedge clk); #1;
            if (bWrite === 1'b1) seenWr = 1'b1;
        end
        check("bothReady", 32'(busB.hostReady), 32'h0000_0001);
        check("bothLatch", 32'(busB.hostReadLatchStrobe), 32'h0000_0001);
        check("bothNoWr", 32'(seenWr), 32'h0000_0000);
        @(negedge clk); busB.hostReadStrobeN = 1'b1; busB.hostWriteStrobeN = 1'b1;
        @(posedge clk); #1;
        check("bothDrop", 32'(busB.hostReady), 32'h0000_0000);
        results();
    end
    // watchdog against a hang
    initial begin
        #20000;
        failures++;
        results();
    end
endmodule
